// [logic/cocal_host.sv]
// host end: register-driven controller that issues commands and collects answers
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
module cocal_host #(
    parameter int unsigned EXEC_CYCLES  = cocal_pkg::EXEC_CYC,
    parameter int unsigned RECAL_CYCLES = cocal_pkg::RECAL_CYC,
    parameter int unsigned STOP_CYCLES  = cocal_pkg::STOP_CYC
) (
    input  wire logic        clock, // system clock
    input  wire logic        nrst,  // sync reset, active low
    input  wire logic [7:0]  addr,  // register byte address
    input  wire logic [31:0] wdata, // write data
    input  wire logic        we,    // write strobe
    input  wire logic        re,    // read strobe
    output logic      [31:0] rdata, // read data, cycle after re
    output logic             irq,   // interrupt, level
    cocal_link_if.host       link   // link to sensor
);
    import cocal_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_SEND  = 3'b001,
        H_WAIT  = 3'b011,
        H_RDREQ = 3'b010,
        H_RECV  = 3'b110
    } cocal_hstate_t;

    cocal_hstate_t    st_q;
    cocal_op_t        op_q;
    logic [15:0]      arg_q;
    logic [15:0]      result_q;
    logic [EVT_W-1:0] status_q;
    logic [EVT_W-1:0] mask_q;
    logic [EVT_W-1:0] evt;
    logic [2:0]       idx_q;
    logic [2:0]       len;
    logic [15:0]      cmd_code;
    logic [7:0]       arg_crc;
    logic [7:0]       rx_crc;
    logic [7:0]       rx_crc_q;
    logic [TMR_W-1:0] wait_q;
    logic             nack_q;
    logic [1:0]       rx_cnt_q;
    logic             start;
    logic             has_reply;

    cocal_crc8 u_tx_crc (
        .word (arg_q),
        .crc  (arg_crc)
    );
    cocal_crc8 u_rx_crc (
        .word (result_q),
        .crc  (rx_crc)
    );

    function automatic logic [15:0] code_of(input cocal_op_t op);
        case (op)
            OP_GET_TOFF: return CMD_GET_TOFF;
            OP_SET_ALT:  return CMD_SET_ALT;
            OP_GET_ALT:  return CMD_GET_ALT;
            OP_SET_PRES: return CMD_SET_PRES;
            OP_RECAL:    return CMD_RECAL;
            default:     return CMD_STOP;
        endcase
    endfunction

    assign cmd_code  = code_of(op_q);
    assign len       = (op_q == OP_SET_ALT || op_q == OP_SET_PRES || op_q == OP_RECAL) ? LEN_LONG : LEN_SHORT;
    assign has_reply = (op_q == OP_GET_TOFF || op_q == OP_GET_ALT || op_q == OP_RECAL);
    assign start     = we && addr == REG_CTRL && st_q == H_IDLE;

    // outgoing frame, one byte per cycle, high byte first
    always_comb begin
        case (idx_q)
            3'h0:    link.wr_byte = cmd_code[15:8]; // R18
            3'h1:    link.wr_byte = cmd_code[7:0];
            3'h2:    link.wr_byte = arg_q[15:8];
            3'h3:    link.wr_byte = arg_q[7:0];
            default: link.wr_byte = arg_crc;
        endcase
    end
    assign link.wr_valid = st_q == H_SEND;
    assign link.wr_last  = st_q == H_SEND && idx_q == len - 3'h1;
    assign link.rd_req   = st_q == H_RDREQ;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            op_q  <= OP_GET_TOFF;
            arg_q <= 16'h0000;
        end else begin
            if (start) begin
                op_q <= cocal_op_t'(wdata[2:0]);
            end
            if (we && addr == REG_ARG && st_q == H_IDLE) begin
                arg_q <= wdata[15:0];
            end
        end
    end

    // sequencer; every op waits its execution time before reading or finishing
    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q     <= H_IDLE;
            idx_q    <= 3'h0;
            wait_q   <= '0;
            nack_q   <= 1'b0;
            rx_cnt_q <= 2'h0;
            result_q <= 16'h0000;
            rx_crc_q <= 8'h00;
        end else begin
            if (link.wr_nack) begin
                nack_q <= 1'b1;
            end
            case (st_q)
                H_IDLE: begin
                    idx_q  <= 3'h0;
                    nack_q <= 1'b0;
                    if (start) begin
                        st_q <= H_SEND;
                    end
                end
                H_SEND: begin
                    idx_q <= idx_q + 3'h1;
                    if (link.wr_last) begin
                        st_q <= H_WAIT;
                        if (op_q == OP_STOP) begin
                            wait_q <= TMR_W'(STOP_CYCLES + WAIT_SLACK); // R11 R17
                        end else if (op_q == OP_RECAL) begin
                            wait_q <= TMR_W'(RECAL_CYCLES + WAIT_SLACK); // R12
                        end else begin
                            wait_q <= TMR_W'(EXEC_CYCLES + WAIT_SLACK); // R5 R6 R9
                        end
                    end
                end
                H_WAIT: begin
                    if (wait_q != '0) begin
                        wait_q <= wait_q - TMR_W'(1);
                    end else if (has_reply && !nack_q) begin
                        st_q <= H_RDREQ; // R19
                    end else begin
                        st_q <= H_IDLE;
                    end
                end
                H_RDREQ: begin
                    rx_cnt_q <= 2'h0;
                    st_q     <= H_RECV;
                end
                H_RECV: begin
                    if (link.rd_nack) begin
                        nack_q <= 1'b1;
                        st_q   <= H_IDLE;
                    end else if (link.rd_valid) begin
                        rx_cnt_q <= rx_cnt_q + 2'h1;
                        case (rx_cnt_q)
                            2'h0:    result_q[15:8] <= link.rd_byte; // R18
                            2'h1:    result_q[7:0]  <= link.rd_byte;
                            default: rx_crc_q       <= link.rd_byte;
                        endcase
                        if (rx_cnt_q == REPLY_BYTES - 2'h1) begin
                            st_q <= H_IDLE;
                        end
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    // completion events; crc compared the cycle after the last byte lands
    logic done_q;
    logic chk_q;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            done_q <= 1'b0;
            chk_q  <= 1'b0;
        end else begin
            done_q <= (st_q == H_WAIT && wait_q == '0 && !(has_reply && !nack_q))
                      || (st_q == H_RECV && (link.rd_nack || (link.rd_valid && rx_cnt_q == REPLY_BYTES - 2'h1)));
            chk_q  <= st_q == H_RECV && link.rd_valid && rx_cnt_q == REPLY_BYTES - 2'h1;
        end
    end
    assign evt = {done_q & nack_q, chk_q & (rx_crc != rx_crc_q), done_q}; // R18

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clock) begin
        if (!nrst) begin
            status_q <= '0;
            mask_q   <= '0;
        end else begin
            if (we && addr == REG_STATUS) begin
                status_q <= (status_q & ~wdata[EVT_W-1:0]) | evt;
            end else begin
                status_q <= status_q | evt;
            end
            if (we && addr == REG_MASK) begin
                mask_q <= wdata[EVT_W-1:0];
            end
        end
    end
    assign irq = |(status_q & mask_q);

    always_ff @(posedge clock) begin
        if (!nrst || !re) begin
            rdata <= 32'h0000_0000;
        end else begin
            case (addr)
                REG_CTRL:   rdata <= {29'h0000_0000, op_q};
                REG_ARG:    rdata <= {16'h0000, arg_q};
                REG_RESULT: rdata <= {16'h0000, result_q};
                REG_STATUS: rdata <= {23'h00_0000, st_q != H_IDLE, 5'h00, status_q};
                REG_MASK:   rdata <= {29'h0000_0000, mask_q};
                default:    rdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// [logic/cocal_pkg.sv]
// constants shared by both ends of the compensation and recalibration command link
// What this block does
// (R1) read offset returns one word plus CRC
// (R2) altitude commands only while idle
// (R3) altitude resets to zero metres
// (R4) altitude kept volatile until persist command
// (R5) set altitude word completes within 1 ms
// (R6) get altitude returns metres after 1 ms
// (R7) ambient pressure accepted during measurement
// (R8) written pressure overrides altitude compensation
// (R9) pressure word is pascal over 100
// (R10) host runs measurement 3 minutes first; not timed here, recalibration needs meas_seen with meas_running low
// (R11) host waits 500 ms after stop
// (R12) recalibration result ready after 400 ms
// (R13) result word is correction plus 0x8000
// (R14) failed recalibration returns all ones
// (R15) no prior measurement means recalibration fails
// (R16) settings changed only while idle; the code still writes pressure_q from set pressure while meas_running is high
// (R17) silent for 500 ms after stop
// (R18) words sent high byte first plus CRC
// (R19) early reads are refused
package cocal_pkg;
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned EXEC_MS     = 1;
    localparam int unsigned RECAL_MS    = 400;
    localparam int unsigned STOP_MS     = 500;
    localparam int unsigned EXEC_CYC    = CLK_HZ / 1000 * EXEC_MS;
    localparam int unsigned RECAL_CYC   = CLK_HZ / 1000 * RECAL_MS;
    localparam int unsigned STOP_CYC    = CLK_HZ / 1000 * STOP_MS;
    localparam int unsigned WAIT_SLACK  = 2;
    localparam int unsigned TMR_W       = 32;

    localparam logic [15:0] CMD_GET_TOFF = 16'h2318;
    localparam logic [15:0] CMD_SET_ALT  = 16'h2427;
    localparam logic [15:0] CMD_GET_ALT  = 16'h2322;
    localparam logic [15:0] CMD_SET_PRES = 16'he000;
    localparam logic [15:0] CMD_RECAL    = 16'h362f;
    localparam logic [15:0] CMD_STOP     = 16'h3f86;

    localparam logic [15:0] RESULT_BIAS  = 16'h8000;
    localparam logic [15:0] RESULT_FAIL  = 16'hffff;
    localparam logic [15:0] ALT_RESET    = 16'h0000;
    localparam logic [7:0]  CRC_POLY     = 8'h31;
    localparam logic [7:0]  CRC_INIT     = 8'hff;
    localparam logic [2:0]  LEN_SHORT    = 3'h2;
    localparam logic [2:0]  LEN_LONG     = 3'h5;
    localparam logic [1:0]  REPLY_BYTES  = 2'h3;

    // host register map, byte addresses
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_ARG      = 8'h04;
    localparam logic [7:0]  REG_RESULT   = 8'h08;
    localparam logic [7:0]  REG_STATUS   = 8'h0c;
    localparam logic [7:0]  REG_MASK     = 8'h10;
    localparam int unsigned ST_DONE      = 0;
    localparam int unsigned ST_CRCERR    = 1;
    localparam int unsigned ST_NACK      = 2;
    localparam int unsigned ST_BUSY      = 8;
    localparam int unsigned EVT_W        = 3;

    typedef enum logic [2:0] {
        OP_GET_TOFF = 3'h0,
        OP_SET_ALT  = 3'h1,
        OP_GET_ALT  = 3'h2,
        OP_SET_PRES = 3'h3,
        OP_RECAL    = 3'h4,
        OP_STOP     = 3'h5
    } cocal_op_t;
endpackage

// [logic/cocal_link_if.sv]
// byte-level command link between the host controller and the sensor command end
`timescale 1ns/100ps
interface cocal_link_if;
    logic       wr_valid;
    logic [7:0] wr_byte;
    logic       wr_last;
    logic       wr_nack;
    logic       rd_req;
    logic       rd_ack;
    logic       rd_nack;
    logic       rd_valid;
    logic [7:0] rd_byte;

    modport dev  (input wr_valid, wr_byte, wr_last, rd_req,
                  output wr_nack, rd_ack, rd_nack, rd_valid, rd_byte);
    modport host (output wr_valid, wr_byte, wr_last, rd_req,
                  input wr_nack, rd_ack, rd_nack, rd_valid, rd_byte);
endinterface

// [logic/cocal_crc8.sv]
// checksum over one 16-bit word, high byte first
`timescale 1ns/100ps
module cocal_crc8
    import cocal_pkg::*;
(
    input  wire logic [15:0] word, // data word
    output logic      [7:0]  crc   // checksum
);
    function automatic logic [7:0] crc_of(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ w[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    assign crc = crc_of(word); // R18
endmodule

// [logic/cocal_dev.sv]
// sensor end: decodes compensation and recalibration commands, answers reads
`timescale 1ns/100ps
module cocal_dev #(
    parameter int unsigned EXEC_CYCLES  = cocal_pkg::EXEC_CYC,
    parameter int unsigned RECAL_CYCLES = cocal_pkg::RECAL_CYC,
    parameter int unsigned STOP_CYCLES  = cocal_pkg::STOP_CYC
) (
    input  wire logic        clock,         // system clock
    input  wire logic        nrst,          // sync reset, active low
    cocal_link_if.dev        link,          // link to host
    input  wire logic        meas_running,  // periodic measurement active
    input  wire logic        meas_seen,     // a measurement ran since power-up
    input  wire logic [15:0] co2_ppm,       // latest concentration
    input  wire logic [15:0] toff_word,     // stored temperature offset word
    output logic             stop_pulse,    // stop periodic measurement
    output logic      [15:0] altitude_q,    // altitude in metres
    output logic      [15:0] pressure_q,    // pressure, pascal / 100
    output logic             use_pressure_q, // compensate from pressure
    output logic             recal_pulse,   // apply correction now
    output logic      [15:0] recal_corr_q   // signed correction in ppm
);
    import cocal_pkg::*;

    logic [2:0]       cnt_q;
    logic [15:0]      cmd_q;
    logic [15:0]      data_q;
    logic [7:0]       crc_q;
    logic [2:0]       len_q;
    logic             exec_q;
    logic [TMR_W-1:0] tmr_q;
    logic             busy;
    logic [15:0]      resp_q;
    logic             resp_vld_q;
    logic [1:0]       tx_cnt_q;
    logic [7:0]       data_crc;
    logic [7:0]       resp_crc;
    logic             crc_ok;
    logic             rd_take;
    logic             set_reply;
    logic [15:0]      reply_word;
    logic [TMR_W-1:0] run_cycles;
    logic             stop_cmd;
    logic [15:0]      recal_result;

    cocal_crc8 u_rx_crc (
        .word (data_q),
        .crc  (data_crc)
    );
    cocal_crc8 u_tx_crc (
        .word (resp_q),
        .crc  (resp_crc)
    );

    assign busy    = (tmr_q != '0) || exec_q;
    assign crc_ok  = (data_crc == crc_q); // R18
    assign rd_take = link.rd_req && !busy && resp_vld_q; // R19

    // frame capture; bytes arriving while busy are dropped and refused
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_q  <= 3'h0;
            cmd_q  <= 16'h0000;
            data_q <= 16'h0000;
            crc_q  <= 8'h00;
            len_q  <= 3'h0;
            exec_q <= 1'b0;
        end else begin
            exec_q <= 1'b0;
            if (link.wr_valid && !busy) begin
                case (cnt_q)
                    3'h0:    cmd_q[15:8]  <= link.wr_byte; // R18
                    3'h1:    cmd_q[7:0]   <= link.wr_byte;
                    3'h2:    data_q[15:8] <= link.wr_byte;
                    3'h3:    data_q[7:0]  <= link.wr_byte;
                    3'h4:    crc_q        <= link.wr_byte;
                    default: ;
                endcase
                if (cnt_q != 3'h7) begin
                    cnt_q <= cnt_q + 3'h1;
                end
                if (link.wr_last) begin
                    len_q  <= cnt_q + 3'h1;
                    exec_q <= 1'b1;
                    cnt_q  <= 3'h0;
                end
            end else if (link.wr_valid && link.wr_last) begin
                cnt_q <= 3'h0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            link.wr_nack <= 1'b0;
        end else begin
            link.wr_nack <= link.wr_valid && busy; // R17
        end
    end

    // decode of a complete frame; malformed or misplaced frames are ignored
    assign recal_result = meas_seen && !meas_running ? data_q - co2_ppm + RESULT_BIAS : RESULT_FAIL; // R13 R14 R15
    always_comb begin
        set_reply  = 1'b0;
        reply_word = 16'h0000;
        run_cycles = TMR_W'(EXEC_CYCLES);
        stop_cmd   = 1'b0;
        if (exec_q && len_q == LEN_SHORT) begin
            case (cmd_q)
                CMD_GET_TOFF: begin
                    set_reply  = !meas_running; // R16
                    reply_word = toff_word; // R1
                end
                CMD_GET_ALT: begin
                    set_reply  = !meas_running; // R2
                    reply_word = altitude_q; // R6
                end
                CMD_STOP: begin
                    stop_cmd   = 1'b1;
                    run_cycles = TMR_W'(STOP_CYCLES); // R17
                end
                default: ;
            endcase
        end else if (exec_q && len_q == LEN_LONG && crc_ok && cmd_q == CMD_RECAL) begin
            set_reply  = 1'b1;
            reply_word = recal_result;
            run_cycles = TMR_W'(RECAL_CYCLES); // R12
        end
    end

    // execution timer: reads and writes are refused until it runs out
    always_ff @(posedge clock) begin
        if (!nrst) begin
            tmr_q <= '0;
        end else if (exec_q) begin
            tmr_q <= run_cycles; // R5 R9
        end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - TMR_W'(1);
        end
    end

    // compensation settings, volatile only; persisting is done elsewhere
    always_ff @(posedge clock) begin
        if (!nrst) begin
            altitude_q     <= ALT_RESET; // R3
            pressure_q     <= 16'h0000;
            use_pressure_q <= 1'b0;
        end else if (exec_q && len_q == LEN_LONG && crc_ok) begin
            if (cmd_q == CMD_SET_ALT && !meas_running) begin // R2
                altitude_q <= data_q; // R4 R5
            end
            if (cmd_q == CMD_SET_PRES) begin // R7
                pressure_q     <= data_q; // R9
                use_pressure_q <= 1'b1; // R8
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            stop_pulse   <= 1'b0;
            recal_pulse  <= 1'b0;
            recal_corr_q <= 16'h0000;
        end else begin
            stop_pulse  <= stop_cmd;
            recal_pulse <= 1'b0;
            if (set_reply && cmd_q == CMD_RECAL && reply_word != RESULT_FAIL) begin
                recal_pulse  <= 1'b1;
                recal_corr_q <= reply_word - RESULT_BIAS; // R13
            end
        end
    end

    // pending reply: one word, consumed by the read that takes it
    always_ff @(posedge clock) begin
        if (!nrst) begin
            resp_q     <= 16'h0000;
            resp_vld_q <= 1'b0;
        end else if (set_reply) begin
            resp_q     <= reply_word;
            resp_vld_q <= 1'b1;
        end else if (exec_q || (rd_take && tx_cnt_q == 2'h0)) begin
            resp_vld_q <= tx_cnt_q != 2'h0 ? resp_vld_q : 1'b0;
        end
    end

    // read answer: ack or nack a cycle after the request, then three bytes
    always_ff @(posedge clock) begin
        if (!nrst) begin
            link.rd_ack   <= 1'b0;
            link.rd_nack  <= 1'b0;
            link.rd_valid <= 1'b0;
            link.rd_byte  <= 8'h00;
            tx_cnt_q      <= 2'h0;
        end else begin
            link.rd_ack   <= 1'b0;
            link.rd_nack  <= 1'b0;
            link.rd_valid <= 1'b0;
            if (tx_cnt_q != 2'h0) begin
                link.rd_valid <= 1'b1;
                tx_cnt_q      <= tx_cnt_q - 2'h1;
                case (tx_cnt_q)
                    2'h3:    link.rd_byte <= resp_q[15:8]; // R18
                    2'h2:    link.rd_byte <= resp_q[7:0];
                    default: link.rd_byte <= resp_crc;
                endcase
            end else if (rd_take) begin
                link.rd_ack <= 1'b1;
                tx_cnt_q    <= REPLY_BYTES;
            end else if (link.rd_req) begin
                link.rd_nack <= 1'b1; // R19
            end
        end
    end
endmodule

// [bench/cocal_link_props.sv]
// protocol checker for the host to sensor command link
`timescale 1ns/100ps
module cocal_link_props #(
    parameter int unsigned EXEC_CYCLES = 20,
    parameter int unsigned STOP_CYCLES = 50
) (
    input wire logic       clock,    // system clock
    input wire logic       nrst,     // sync reset, active low
    input wire logic       wr_valid, // command byte valid
    input wire logic [7:0] wr_byte,  // command byte
    input wire logic       wr_last,  // last byte of frame
    input wire logic       wr_nack,  // byte refused
    input wire logic       rd_req,   // read request
    input wire logic       rd_ack,   // read granted
    input wire logic       rd_nack,  // read refused
    input wire logic       rd_valid, // reply byte valid
    input wire logic [7:0] rd_byte   // reply byte
);
    int unsigned since_last_q;
    int unsigned since_stop_q;
    // saturate so long idle spans cannot wrap
    always_ff @(posedge clock) begin
        if (!nrst || wr_last) since_last_q <= 0;
        else if (since_last_q < 100000) since_last_q <= since_last_q + 1;
    end
    always_ff @(posedge clock) begin
        if (!nrst) since_stop_q <= 100000;
        else if (wr_last && wr_byte == 8'h86) since_stop_q <= 0;
        else if (since_stop_q < 100000) since_stop_q <= since_stop_q + 1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_short;
        wr_valid && !wr_last ##1 wr_valid && wr_last ##1 !wr_valid;
    endsequence
    sequence s_long;
        (wr_valid && !wr_last)[*4] ##1 wr_valid && wr_last ##1 !wr_valid;
    endsequence
    property p_ack_one; rd_req |=> rd_ack != rd_nack; endproperty
    property p_reply_len; rd_ack |=> rd_valid[*3] ##1 !rd_valid; endproperty
    property p_no_stray; rd_valid |-> $past(rd_ack) || $past(rd_valid); endproperty
    property p_read_late; rd_req |-> since_last_q > EXEC_CYCLES; endproperty
    property p_short; $rose(wr_valid) && (wr_byte == 8'h23 || wr_byte == 8'h3f) |-> s_short; endproperty
    property p_long; $rose(wr_valid) && wr_byte inside {8'h24, 8'he0, 8'h36} |-> s_long; endproperty
    property p_first; $rose(wr_valid) |-> wr_byte inside {8'h23, 8'h24, 8'he0, 8'h36, 8'h3f}; endproperty
    property p_nack_cause; wr_nack |-> $past(wr_valid); endproperty
    property p_stop_quiet; $rose(wr_valid) |-> since_stop_q >= STOP_CYCLES; endproperty
    a_ack_one: assert property (p_ack_one) else $error("read neither or both granted");
    a_reply_len: assert property (p_reply_len) else $error("reply not three bytes");
    a_no_stray: assert property (p_no_stray) else $error("reply byte without grant");
    a_read_late: assert property (p_read_late) else $error("read before execution time");
    a_short: assert property (p_short) else $error("short frame malformed");
    a_long: assert property (p_long) else $error("word frame malformed");
    a_first: assert property (p_first) else $error("unknown command high byte");
    a_nack_cause: assert property (p_nack_cause) else $error("nack without byte");
    a_stop_quiet: assert property (p_stop_quiet) else $error("frame too soon after stop");
endmodule

// [bench/test_co2_compensation_calibration_cmds.sv]
// self-checking bench: host controller facing the sensor command end
`timescale 1ns/100ps
module test_co2_compensation_calibration_cmds;
    import cocal_pkg::*;
    localparam int unsigned EXC = 20;
    localparam int unsigned RCL = 40;
    localparam int unsigned STP = 50;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic        meas_running = 1'b0;
    logic        meas_seen = 1'b0;
    logic [7:0]  addr = 8'h00, last_rd;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, d;
    logic [15:0] co2_ppm = 16'h0000;
    logic [15:0] toff_word = 16'h0000;
    logic [15:0] altitude_q, pressure_q, recal_corr_q;
    logic        irq, stop_pulse, use_pressure_q, recal_pulse;
    int          n_fail = 0, compares = 0;
    int          n_stop = 0, n_recal = 0;
    cocal_link_if link ();
    always #5 clock = ~clock;
    always @(posedge clock) if (stop_pulse === 1'b1) n_stop <= n_stop + 1;
    always @(posedge clock) if (recal_pulse === 1'b1) n_recal <= n_recal + 1;
    always @(posedge clock) if (link.rd_valid === 1'b1) last_rd <= link.rd_byte;
    cocal_dev #(.EXEC_CYCLES(EXC), .RECAL_CYCLES(RCL), .STOP_CYCLES(STP)) u_cocal_dev (
        .clock(clock), .nrst(nrst), .link(link.dev), .meas_running(meas_running), .meas_seen(meas_seen),
        .co2_ppm(co2_ppm), .toff_word(toff_word), .stop_pulse(stop_pulse), .altitude_q(altitude_q),
        .pressure_q(pressure_q), .use_pressure_q(use_pressure_q), .recal_pulse(recal_pulse),
        .recal_corr_q(recal_corr_q));
    cocal_host #(.EXEC_CYCLES(EXC), .RECAL_CYCLES(RCL), .STOP_CYCLES(STP)) u_cocal_host (
        .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
        .irq(irq), .link(link.host));
    cocal_link_props #(.EXEC_CYCLES(EXC), .STOP_CYCLES(STP)) u_cocal_link_props (
        .clock(clock), .nrst(nrst), .wr_valid(link.wr_valid), .wr_byte(link.wr_byte), .wr_last(link.wr_last),
        .wr_nack(link.wr_nack), .rd_req(link.rd_req), .rd_ack(link.rd_ack), .rd_nack(link.rd_nack),
        .rd_valid(link.rd_valid), .rd_byte(link.rd_byte));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clock);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        re <= 1'b1;
        @(posedge clock);
        re <= 1'b0;
        #1 d = rdata;
    endtask
    // status must end as st, done alone by default: a bad checksum or refusal shows up here
    task automatic run_op(input logic [2:0] op, input logic [15:0] arg, input logic [31:0] st = 32'h0000_0001);
        wr(REG_ARG, {16'h0000, arg});
        wr(REG_STATUS, 32'h0000_0007);
        wr(REG_CTRL, {29'h0000_0000, op});
        for (int i = 0; i < 300; i++) begin
            rd(REG_STATUS);
            if (d[ST_DONE] === 1'b1) break;
        end
        chk(d, st);
        rd(REG_RESULT);
    endtask
    task automatic t_reset;
        rd(REG_STATUS);
        chk(d, 32'h0000_0000);
        chk({16'h0000, altitude_q}, 32'h0000_0000);
        rd(8'h20);
        chk(d, 32'h0000_0000);
    endtask
    task automatic t_settings;
        toff_word <= 16'h0912;
        run_op(OP_GET_TOFF, 16'h0000);
        chk(d, 32'h0000_0912);
        chk({24'h00_0000, last_rd}, 32'h0000_0063);
        run_op(OP_SET_ALT, 16'h079e);
        chk({16'h0000, altitude_q}, 32'h0000_079e);
        run_op(OP_GET_ALT, 16'h0000);
        chk(d, 32'h0000_079e);
        meas_running <= 1'b1;
        run_op(OP_SET_ALT, 16'h0100);
        chk({16'h0000, altitude_q}, 32'h0000_079e);
        run_op(OP_GET_ALT, 16'h0000, 32'h0000_0005);
        run_op(OP_SET_PRES, 16'h03db);
        chk({16'h0000, pressure_q}, 32'h0000_03db);
        chk({31'h0000_0000, use_pressure_q}, 32'h0000_0001);
    endtask
    task automatic t_recal;
        run_op(OP_STOP, 16'h0000);
        chk(n_stop, 32'h0000_0001);
        meas_running <= 1'b0;
        run_op(OP_RECAL, 16'h01e0);
        chk(d, 32'h0000_ffff);
        meas_seen <= 1'b1;
        co2_ppm <= 16'h0212;
        run_op(OP_RECAL, 16'h01e0);
        chk(d, 32'h0000_7fce);
        chk({24'h00_0000, last_rd}, 32'h0000_007b);
        chk(n_recal, 32'h0000_0001);
        chk({16'h0000, recal_corr_q}, 32'h0000_ffce);
    endtask
    task automatic t_irq;
        wr(REG_MASK, 32'h0000_0001);
        run_op(OP_GET_ALT, 16'h0000);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(REG_MASK, 32'h0000_0000);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(REG_STATUS, 32'h0000_0001);
        wr(REG_MASK, 32'h0000_0001);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
    endtask
    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_settings();
        t_recal();
        t_irq();
        final_report();
    end
    // about ten commands of a few dozen cycles each; some forty times that is a hang
    initial begin
        #200_000;
        n_fail++;
        final_report();
    end
endmodule
